// >>> rtl/nc_core.sv
// Nibble CPU datapath: instruction pointer, one-level stack, program memory,
// nibble data memory with port registers and status word, and the 4-bit ALU.
// Assumes an outside decoder issuing one command per cycle and pins that are
// asynchronous to SYS_CLK.
// Holds no instruction decode; skip is reported, never acted on here.
// Program store has no reset; it must be loaded before it is fetched.
`timescale 1ns/1ps
`default_nettype none
module nc_core (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire nc_pkg::nc_ip_cmd_e IP_CMD,
  input wire logic [nc_pkg::NC_IP_W-1:0] IP_TARGET,
  output logic [nc_pkg::NC_IP_W-1:0] IP_VALUE,
  output logic [nc_pkg::NC_WORD_W-1:0] PROG_WORD,
  input wire logic PROG_WR_EN,
  input wire logic [nc_pkg::NC_IP_W-1:0] PROG_WR_ADDR,
  input wire logic [nc_pkg::NC_WORD_W-1:0] PROG_WR_DATA,
  input wire logic MEM_WR,
  input wire logic [nc_pkg::NC_ADDR_W-1:0] MEM_ADDR,
  input wire logic [nc_pkg::NC_NIB_W-1:0] MEM_WDATA,
  output logic [nc_pkg::NC_NIB_W-1:0] MEM_RDATA,
  input wire logic ALU_GO,
  input wire nc_pkg::nc_alu_op_e ALU_OP,
  input wire logic [nc_pkg::NC_ADDR_W-1:0] ALU_ADDR,
  input wire logic [nc_pkg::NC_NIB_W-1:0] ALU_IMM,
  output logic [nc_pkg::NC_NIB_W-1:0] ALU_RESULT,
  output logic SKIP,
  output logic [nc_pkg::NC_NIB_W-1:0] FLAGS,
  input wire logic [nc_pkg::NC_PORTS*nc_pkg::NC_NIB_W-1:0] PORT_PIN_IN,
  output logic [nc_pkg::NC_PORTS*nc_pkg::NC_NIB_W-1:0] PORT_PIN_OUT,
  output logic [nc_pkg::NC_PORTS*nc_pkg::NC_NIB_W-1:0] PORT_PIN_OE
);
  import nc_pkg::*;

  // All state except the program store in one record
  typedef struct packed {
    logic [NC_IP_W-1:0] ip;
    logic [NC_IP_W-1:0] stack;
    logic [NC_COLS-1:0][NC_NIB_W-1:0] gp;
    logic [NC_PORTS-1:0][NC_NIB_W-1:0] port_reg;
    logic [NC_PORTS-1:0] out_mode;
    logic bcd;
    logic cmp;
    logic cy;
    logic z;
    logic [NC_NIB_W-1:0] rdata;
    logic [NC_NIB_W-1:0] alu_y;
    logic skip;
    logic [NC_WORD_W-1:0] prog_word;
    logic [NC_PORTS*NC_NIB_W-1:0] sync1;
    logic [NC_PORTS*NC_NIB_W-1:0] sync2;
  } nc_state_s;

  nc_state_s s_q;
  nc_state_s s_d;

  // Program store kept apart from the record so it maps onto a RAM macro
  logic [NC_WORD_W-1:0] rom [NC_ROM_DEPTH];

  logic [NC_NIB_W-1:0] opnd_a;
  logic [NC_NIB_W-1:0] alu_y;
  logic alu_cy;
  logic alu_zero;
  logic alu_writes;
  logic alu_sets_cy;
  logic alu_sets_z;
  logic alu_skip;
  logic [4:0] sum;
  logic [4:0] dif;
  logic cin;
  logic [4:0] dec_sum;
  logic [NC_NIB_W-1:0] dec_add_y;
  logic [NC_NIB_W-1:0] dec_sub_y;
  logic dec_add_cy;
  logic dec_sub_cy;
  logic wr_en;
  logic [NC_ADDR_W-1:0] wr_addr;
  logic [NC_NIB_W-1:0] wr_data;

  // Nibble read: pins for port slots, packed status, zero for holes
  function automatic logic [NC_NIB_W-1:0] read_nibble(
    input logic [NC_ADDR_W-1:0] addr,
    input nc_state_s st
  );
    logic [NC_NIB_W-1:0] v;
    v = NC_NIB_RESET;
    if (addr[6:4] == NC_ROW_POINTER) begin
      v = st.gp[addr[3:0]];
    end else if (addr[6:2] == NC_PORT_BASE[6:2]) begin
      v = st.sync2[addr[1:0]*NC_NIB_W +: NC_NIB_W];
      if (addr[1:0] == NC_PORT_B_IDX) begin
        v = v & NC_PORT_B_MASK;
      end
    end else if (addr == NC_PSW_LOW) begin
      v = {3'h0, st.bcd};
    end else if (addr == NC_PSW_HIGH) begin
      v = {st.cmp, st.cy, st.z, 1'b0};
    end
    return v;
  endfunction

  // ALU operand comes straight from data memory, second from the immediate
  assign opnd_a = read_nibble(ALU_ADDR, s_q);

  // Carry-in only for the with-carry forms
  assign cin = (ALU_OP == NC_OP_ADDC || ALU_OP == NC_OP_SUBC) ? s_q.cy : 1'b0;
  assign sum = {1'b0, opnd_a} + {1'b0, ALU_IMM} + {4'h0, cin};
  assign dif = {1'b0, opnd_a} - {1'b0, ALU_IMM} - {4'h0, cin};

  // Decimal correction: in range, the binary value moved by ten.
  // Out of range only carry and a value of ten or more are promised,
  // so an over-range sum gets the ten pattern forced in rather than
  // wrapping back to a digit that looks legal.
  assign dec_sum = sum - NC_DEC_BASE;
  always_comb begin
    dec_add_cy = (sum > NC_DEC_MAX);
    dec_add_y = sum[3:0];
    if (dec_add_cy) begin
      dec_add_y = dec_sum[3:0];
    end
    if (dec_add_cy && dec_sum > NC_DEC_MAX) begin
      dec_add_y = dec_sum[3:0] | NC_DEC_BASE_NIB;
    end
    // A difference above nine is as illegal as a borrow
    dec_sub_cy = (dif > NC_DEC_MAX);
    dec_sub_y = dif[3:0];
    if (dif[4]) begin
      dec_sub_y = dif[3:0] + NC_DEC_BASE_NIB;
    end
  end

  // Combinational ALU; the record update below decides what is kept
  always_comb begin
    alu_y = opnd_a;
    alu_cy = s_q.cy;
    alu_writes = 1'b0;
    alu_sets_cy = 1'b0;
    alu_sets_z = 1'b0;
    alu_skip = 1'b0;
    case (ALU_OP)
      NC_OP_ADD, NC_OP_ADDC: begin
        alu_writes = 1'b1;
        alu_sets_cy = 1'b1;
        alu_sets_z = 1'b1;
        if (s_q.bcd) begin
          alu_cy = dec_add_cy;
          alu_y = dec_add_y;
        end else begin
          alu_cy = sum[4];
          alu_y = sum[3:0];
        end
      end
      NC_OP_SUB, NC_OP_SUBC: begin
        alu_writes = 1'b1;
        alu_sets_cy = 1'b1;
        alu_sets_z = 1'b1;
        if (s_q.bcd) begin
          alu_cy = dec_sub_cy;
          alu_y = dec_sub_y;
        end else begin
          alu_cy = dif[4];
          alu_y = dif[3:0];
        end
      end
      NC_OP_AND: begin
        alu_writes = 1'b1;
        alu_y = opnd_a & ALU_IMM;
      end
      NC_OP_OR: begin
        alu_writes = 1'b1;
        alu_y = opnd_a | ALU_IMM;
      end
      NC_OP_XOR: begin
        alu_writes = 1'b1;
        alu_y = opnd_a ^ ALU_IMM;
      end
      NC_OP_LOAD: begin
        alu_writes = 1'b1;
        alu_y = ALU_IMM;
      end
      NC_OP_RORC: begin
        // Rotate right through carry
        alu_writes = 1'b1;
        alu_sets_cy = 1'b1;
        alu_y = {s_q.cy, opnd_a[3:1]};
        alu_cy = opnd_a[0];
      end
      NC_OP_SKIP_IF_EQUAL: begin
        alu_sets_z = 1'b1;
        alu_y = dif[3:0];
        alu_skip = (opnd_a == ALU_IMM);
      end
      NC_OP_SKIP_IF_UNEQUAL: begin
        alu_sets_z = 1'b1;
        alu_y = dif[3:0];
        alu_skip = (opnd_a != ALU_IMM);
      end
      NC_OP_SKIP_IF_GREATER_OR_EQUAL: begin
        alu_sets_z = 1'b1;
        alu_y = dif[3:0];
        alu_skip = (opnd_a >= ALU_IMM);
      end
      NC_OP_SKIP_IF_LESS_THAN: begin
        alu_sets_z = 1'b1;
        alu_y = dif[3:0];
        alu_skip = (opnd_a < ALU_IMM);
      end
      NC_OP_TEST_TRUE: begin
        alu_skip = ((opnd_a & ALU_IMM) == ALU_IMM);
      end
      NC_OP_TEST_FALSE: begin
        alu_skip = ((opnd_a & ALU_IMM) == NC_NIB_RESET);
      end
      default: begin
        alu_y = opnd_a;
      end
    endcase
  end

  // Zero test on the value the op produced, stored or not
  assign alu_zero = (alu_y == NC_NIB_RESET);

  // One write path; an ALU result wins over a plain store in the same cycle
  assign wr_en = (ALU_GO && alu_writes) || MEM_WR;
  assign wr_addr = (ALU_GO && alu_writes) ? ALU_ADDR : MEM_ADDR;
  assign wr_data = (ALU_GO && alu_writes) ? alu_y : MEM_WDATA;

  // Next-state of the whole record
  always_comb begin
    s_d = s_q;
    // Two-flop pin synchroniser; only the second stage is ever read
    s_d.sync1 = PORT_PIN_IN;
    s_d.sync2 = s_q.sync1;
    // Skip is a pulse, low unless this cycle's op raises it
    s_d.skip = 1'b0;

    // Instruction pointer sequencing
    case (IP_CMD)
      NC_IP_NEXT: begin
        s_d.ip = s_q.ip + NC_IP_STEP;
      end
      NC_IP_BRANCH: begin
        s_d.ip = IP_TARGET;
      end
      NC_IP_CALL: begin
        // A second call overwrites the only level
        s_d.stack = s_q.ip + NC_IP_STEP;
        s_d.ip = IP_TARGET;
      end
      NC_IP_RETURN: begin
        // A return before any call since reset loads the cleared stack
        s_d.ip = s_q.stack;
      end
      default: begin
        s_d.ip = s_q.ip;
      end
    endcase

    // Data memory store with address decode
    // Holes in the map fall through and are dropped
    if (wr_en) begin
      if (wr_addr[6:4] == NC_ROW_POINTER) begin
        s_d.gp[wr_addr[3:0]] = wr_data;
      end else if (wr_addr[6:2] == NC_PORT_BASE[6:2]) begin
        // Output mode is sticky until reset
        s_d.out_mode[wr_addr[1:0]] = 1'b1;
        if (wr_addr[1:0] == NC_PORT_B_IDX) begin
          s_d.port_reg[wr_addr[1:0]] = wr_data & NC_PORT_B_MASK;
        end else begin
          s_d.port_reg[wr_addr[1:0]] = wr_data;
        end
      end else if (wr_addr == NC_PSW_LOW) begin
        s_d.bcd = wr_data[NC_BCD_BIT];
      end else if (wr_addr == NC_PSW_HIGH) begin
        // Flags stored as written, compare mode ignored
        s_d.cmp = wr_data[NC_CMP_BIT];
        s_d.cy = wr_data[NC_CY_BIT];
        s_d.z = wr_data[NC_Z_BIT];
      end
    end

    // Flag effects of the ALU override a store into the status word
    if (ALU_GO) begin
      s_d.alu_y = alu_y;
      s_d.skip = alu_skip;
      if (alu_sets_cy) begin
        s_d.cy = alu_cy;
      end
      if (alu_sets_z) begin
        if (!alu_zero) begin
          s_d.z = 1'b0;
        end else if (!s_q.cmp) begin
          s_d.z = 1'b1;
        end else begin
          s_d.z = s_q.z;
        end
      end
    end

    // Fetch one cycle behind the pointer
    s_d.prog_word = rom[s_q.ip];

    // Registered read port, same decode as the ALU operand
    s_d.rdata = read_nibble(MEM_ADDR, s_q);
  end

  // Record register; reset clears pointer and status to zero
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Program memory: one 16-bit word per pointer value
  always_ff @(posedge SYS_CLK) begin
    if (PROG_WR_EN) begin
      rom[PROG_WR_ADDR] <= PROG_WR_DATA;
    end
  end

  // Pin drivers per port; port B is open drain and its top bit is absent
  // Open drain pulls low only where the register holds a zero
  for (genvar p = 0; p < NC_PORTS; p++) begin : g_port
    if (p == int'(NC_PORT_B_IDX)) begin : g_od
      assign PORT_PIN_OUT[p*NC_NIB_W +: NC_NIB_W] = NC_NIB_RESET;
      assign PORT_PIN_OE[p*NC_NIB_W +: NC_NIB_W] =
        {NC_NIB_W{s_q.out_mode[p]}} & ~s_q.port_reg[p] & NC_PORT_B_MASK;
    end else begin : g_pp
      assign PORT_PIN_OUT[p*NC_NIB_W +: NC_NIB_W] = s_q.port_reg[p];
      assign PORT_PIN_OE[p*NC_NIB_W +: NC_NIB_W] = {NC_NIB_W{s_q.out_mode[p]}};
    end
  end

  // Output taps
  // Every data output comes straight from the record
  assign IP_VALUE = s_q.ip;
  assign PROG_WORD = s_q.prog_word;
  assign MEM_RDATA = s_q.rdata;
  assign ALU_RESULT = s_q.alu_y;
  assign SKIP = s_q.skip;
  assign FLAGS = {s_q.cmp, s_q.cy, s_q.z, s_q.bcd};
endmodule
`default_nettype wire

// >>> rtl/nc_pkg.sv
// Constants and encodings shared by the nibble CPU datapath.
// Assumes a single system clock and a decoder outside that drives the command ports.
`default_nettype none
package nc_pkg;
  // Widths and depths
  localparam int NC_IP_W = 9;
  localparam int NC_WORD_W = 16;
  localparam int NC_ROM_DEPTH = 512;
  localparam int NC_NIB_W = 4;
  localparam int NC_ADDR_W = 7;
  localparam int NC_COLS = 16;
  localparam int NC_PORTS = 4;

  // Data memory map
  localparam logic [2:0] NC_GP_ROW = 3'h0;
  localparam logic [2:0] NC_ROW_POINTER = 3'h0;
  localparam logic [6:0] NC_PORT_BASE = 7'h70;
  localparam logic [6:0] NC_PSW_LOW = 7'h7E;
  localparam logic [6:0] NC_PSW_HIGH = 7'h7F;
  localparam logic [1:0] NC_PORT_B_IDX = 2'h1;
  localparam logic [3:0] NC_PORT_B_MASK = 4'h7;

  // Status bit positions
  localparam int NC_BCD_BIT = 0;
  localparam int NC_CMP_BIT = 3;
  localparam int NC_CY_BIT = 2;
  localparam int NC_Z_BIT = 1;

  // Reset values and arithmetic limits
  localparam logic [8:0] NC_IP_RESET = 9'h000;
  localparam logic [8:0] NC_IP_STEP = 9'h001;
  localparam logic [3:0] NC_NIB_RESET = 4'h0;
  localparam logic [4:0] NC_DEC_MAX = 5'h09;
  localparam logic [4:0] NC_DEC_BASE = 5'h0A;
  localparam logic [3:0] NC_DEC_BASE_NIB = 4'hA;

  // Instruction pointer commands
  typedef enum logic [2:0] {
    NC_IP_HOLD = 3'h0,
    NC_IP_NEXT = 3'h1,
    NC_IP_BRANCH = 3'h2,
    NC_IP_CALL = 3'h3,
    NC_IP_RETURN = 3'h4
  } nc_ip_cmd_e;

  // ALU operations
  typedef enum logic [3:0] {
    NC_OP_ADD = 4'h0,
    NC_OP_ADDC = 4'h1,
    NC_OP_SUB = 4'h2,
    NC_OP_SUBC = 4'h3,
    NC_OP_AND = 4'h4,
    NC_OP_OR = 4'h5,
    NC_OP_XOR = 4'h6,
    NC_OP_LOAD = 4'h7,
    NC_OP_RORC = 4'h8,
    NC_OP_SKIP_IF_EQUAL = 4'h9,
    NC_OP_SKIP_IF_UNEQUAL = 4'hA,
    NC_OP_SKIP_IF_GREATER_OR_EQUAL = 4'hB,
    NC_OP_SKIP_IF_LESS_THAN = 4'hC,
    NC_OP_TEST_TRUE = 4'hD,
    NC_OP_TEST_FALSE = 4'hE
  } nc_alu_op_e;
endpackage
`default_nettype wire

// >>> tb/nc_core_monitor.sv
// Port checker for the nibble CPU datapath.
// Assumes it is bound into nc_core: one clock, synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module nc_core_monitor (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire nc_pkg::nc_ip_cmd_e IP_CMD,
  input wire logic [8:0] IP_TARGET,
  input wire logic [8:0] IP_VALUE,
  input wire logic MEM_WR,
  input wire logic [6:0] MEM_ADDR,
  input wire logic [3:0] MEM_WDATA,
  input wire logic [3:0] MEM_RDATA,
  input wire logic ALU_GO,
  input wire nc_pkg::nc_alu_op_e ALU_OP,
  input wire logic [3:0] ALU_RESULT,
  input wire logic [3:0] FLAGS,
  input wire logic [15:0] PORT_PIN_OUT,
  input wire logic [15:0] PORT_PIN_OE
);
  import nc_pkg::*;
  logic is_arith;
  logic is_compare;
  default clocking cb @(posedge SYS_CLK); endclocking
  // Operation classes; a store in the same cycle is left out of flag checks
  assign is_arith = ALU_OP inside {[NC_OP_ADD:NC_OP_SUBC]};
  assign is_compare = ALU_OP inside {[NC_OP_SKIP_IF_EQUAL:NC_OP_SKIP_IF_LESS_THAN]};
  property p_reset_clear;
    !RST_B |=> IP_VALUE == NC_IP_RESET && FLAGS == 4'h0;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("reset state wrong");
  property p_ip_step;
    disable iff (!RST_B) IP_CMD == NC_IP_NEXT |=> IP_VALUE == $past(IP_VALUE) + NC_IP_STEP;
  endproperty
  a_ip_step: assert property (p_ip_step)
    else $error("pointer step wrong");
  property p_ip_load;
    disable iff (!RST_B) IP_CMD inside {NC_IP_BRANCH, NC_IP_CALL} |=> IP_VALUE == $past(IP_TARGET);
  endproperty
  a_ip_load: assert property (p_ip_load)
    else $error("pointer load wrong");
  property p_status_high;
    disable iff (!RST_B) MEM_ADDR == NC_PSW_HIGH |=> MEM_RDATA == {$past(FLAGS[3:1]), 1'h0};
  endproperty
  a_status_high: assert property (p_status_high)
    else $error("high status read wrong");
  property p_status_low;
    disable iff (!RST_B) MEM_ADDR == NC_PSW_LOW |=> MEM_RDATA == {3'h0, $past(FLAGS[0])};
  endproperty
  a_status_low: assert property (p_status_low)
    else $error("low status read wrong");
  property p_compare_carry;
    disable iff (!RST_B) ALU_GO && !MEM_WR && is_compare |=> $stable(FLAGS[NC_CY_BIT]);
  endproperty
  a_compare_carry: assert property (p_compare_carry)
    else $error("compare moved carry");
  property p_zero_rule;
    disable iff (!RST_B) ALU_GO && !MEM_WR && (is_arith || is_compare) |=> FLAGS[NC_Z_BIT] ==
      (ALU_RESULT == 4'h0 && ($past(FLAGS[NC_CMP_BIT]) ? $past(FLAGS[NC_Z_BIT]) : 1'h1));
  endproperty
  a_zero_rule: assert property (p_zero_rule)
    else $error("zero flag wrong");
  property p_port_mode;
    disable iff (!RST_B) MEM_WR && !ALU_GO && MEM_ADDR == 7'h72
      |=> PORT_PIN_OE[11:8] == 4'hF && PORT_PIN_OUT[11:8] == $past(MEM_WDATA);
  endproperty
  a_port_mode: assert property (p_port_mode)
    else $error("port write not driven");
  property p_port_b_top;
    disable iff (!RST_B) PORT_PIN_OE[7] == 1'h0 && PORT_PIN_OUT[7:4] == 4'h0;
  endproperty
  a_port_b_top: assert property (p_port_b_top)
    else $error("open-drain port drives high");
endmodule
`default_nettype wire

// >>> tb/nc_core_tb.sv
// Self-checking bench for the nibble CPU datapath, driven at its own ports.
// Assumes nc_pkg, nc_core and nc_core_monitor are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end
module nc_core_tb;
  import nc_pkg::*;
  logic sys_clk, rst_b = 1'h0, prog_wr_en = 1'h0, mem_wr = 1'h0, alu_go = 1'h0, skip, carry;
  nc_ip_cmd_e ip_cmd = NC_IP_HOLD;
  nc_alu_op_e alu_op = NC_OP_ADD, op;
  logic [8:0] ip_target = 9'h000, prog_wr_addr = 9'h000, ip_value;
  logic [15:0] prog_wr_data = 16'h0000, pin_in = 16'h95CA, prog_word, pin_out, pin_oe;
  logic [6:0] mem_addr = 7'h00, alu_addr = 7'h00;
  logic [3:0] mem_wdata = 4'h0, alu_imm = 4'h0, mem_rdata, alu_result, flags;
  logic [4:0] e;
  logic [8:0] pa [0:5] = '{9'h000, 9'h001, 9'h1FF, 9'h040, 9'h041, 9'h080};
  // Arithmetic cases: decimal flag, operation, operand, immediate
  logic [12:0] at [0:8] = '{13'h0097, 13'h0134, 13'h0235, 13'h0354, 13'h1075, 13'h1144,
    13'h1235, 13'h1099, 13'h1309};
  // Decimal cases outside the defined ranges: operation, operand, immediate
  logic [11:0] ov [0:2] = '{12'h0FF, 12'h2C1, 12'h20F};
  int bad_count = 0;
  int n_checks = 0;
  nc_core dut (.SYS_CLK(sys_clk), .RST_B(rst_b), .IP_CMD(ip_cmd), .IP_TARGET(ip_target),
    .IP_VALUE(ip_value), .PROG_WORD(prog_word), .PROG_WR_EN(prog_wr_en),
    .PROG_WR_ADDR(prog_wr_addr), .PROG_WR_DATA(prog_wr_data), .MEM_WR(mem_wr),
    .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata), .ALU_GO(alu_go),
    .ALU_OP(alu_op), .ALU_ADDR(alu_addr), .ALU_IMM(alu_imm), .ALU_RESULT(alu_result),
    .SKIP(skip), .FLAGS(flags), .PORT_PIN_IN(pin_in), .PORT_PIN_OUT(pin_out),
    .PORT_PIN_OE(pin_oe));
  // 250 MHz clock
  initial begin
    sys_clk = 1'h0;
    forever #2 sys_clk = ~sys_clk;
  end
  // Expected sum or difference with carry; decimal wraps by ten
  function automatic logic [4:0] arith(input nc_alu_op_e o, input logic [3:0] a, b,
      input logic c, input logic dec);
    int s;
    s = (o == NC_OP_ADD || o == NC_OP_ADDC) ? a + b : a - b;
    if (o == NC_OP_ADDC) s = s + c;
    if (o == NC_OP_SUBC) s = s - c;
    if (s < 0) return {1'h1, 4'(s + (dec ? 10 : 16))};
    if (s > (dec ? 9 : 15)) return {1'h1, 4'(s - (dec ? 10 : 16))};
    return {1'h0, 4'(s)};
  endfunction
  task automatic do_reset;
    rst_b <= 1'h0;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'h1;
  endtask
  // Strobe drops for a cycle so it never toggles twice in one step
  task automatic wr(input logic [6:0] a, input logic [3:0] d);
    mem_wr <= 1'h1;
    mem_addr <= a;
    mem_wdata <= d;
    @(posedge sys_clk);
    mem_wr <= 1'h0;
    @(posedge sys_clk);
  endtask
  task automatic rdc(input logic [6:0] a, input logic [3:0] x);
    mem_addr <= a;
    @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK(mem_rdata, x)
    @(posedge sys_clk);
  endtask
  task automatic ipc(input nc_ip_cmd_e c, input logic [8:0] t, x);
    ip_cmd <= c;
    ip_target <= t;
    @(posedge sys_clk);
    ip_cmd <= NC_IP_HOLD;
    @(negedge sys_clk);
    `CHK(ip_value, x)
    @(negedge sys_clk);
    `CHK(prog_word, {7'h35, x})
    @(posedge sys_clk);
  endtask
  // Skip is a one-cycle pulse, so it is sampled mid-cycle right after the launch edge
  task automatic alu(input nc_alu_op_e o, input logic [3:0] b, r, f, input logic s);
    alu_go <= 1'h1;
    alu_op <= o;
    alu_addr <= 7'h06;
    alu_imm <= b;
    @(posedge sys_clk);
    alu_go <= 1'h0;
    @(negedge sys_clk);
    `CHK(alu_result, r)
    `CHK(flags, f)
    `CHK(skip, s)
    @(posedge sys_clk);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Run far beyond the few hundred cycles the sequence needs
  initial begin
    #200000;
    bad_count++;
    stop_test;
  end
  initial begin
    do_reset;
    foreach (pa[i]) begin
      prog_wr_en <= 1'h1;
      prog_wr_addr <= pa[i];
      prog_wr_data <= {7'h35, pa[i]};
      @(posedge sys_clk);
    end
    prog_wr_en <= 1'h0;
    wr(NC_PSW_HIGH, 4'hF);
    do_reset;
    @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK(ip_value, NC_IP_RESET)
    `CHK(prog_word, 16'h6A00)
    `CHK(flags, 4'h0)
    @(posedge sys_clk);
    ipc(NC_IP_NEXT, 9'h000, 9'h001);
    ipc(NC_IP_BRANCH, 9'h1FF, 9'h1FF);
    ipc(NC_IP_NEXT, 9'h000, 9'h000);
    ipc(NC_IP_CALL, 9'h040, 9'h040);
    ipc(NC_IP_CALL, 9'h080, 9'h080);
    ipc(NC_IP_RETURN, 9'h000, 9'h041);
    ipc(NC_IP_RETURN, 9'h000, 9'h041);
    $display("test pointer done");
    `CHK(pin_oe, 16'h0000)
    for (int i = 0; i < 16; i++) wr(7'(i), 4'(i ^ 5));
    for (int i = 0; i < 16; i++) rdc(7'(i), 4'(i ^ 5));
    wr(7'h25, 4'hF);
    rdc(7'h25, 4'h0);
    wr(7'h70, 4'h5);
    wr(7'h71, 4'hF);
    wr(7'h72, 4'h3);
    wr(7'h73, 4'h6);
    `CHK(pin_out, 16'h6305)
    `CHK(pin_oe, 16'hFF0F)
    wr(7'h71, 4'h0);
    `CHK(pin_oe, 16'hFF7F)
    rdc(7'h70, 4'hA);
    rdc(7'h71, 4'h4);
    rdc(7'h72, 4'h5);
    $display("test memory done");
    wr(NC_PSW_HIGH, 4'hF);
    wr(NC_PSW_LOW, 4'hF);
    rdc(NC_PSW_HIGH, 4'hE);
    rdc(NC_PSW_LOW, 4'h1);
    `CHK(flags, 4'hF)
    wr(NC_PSW_HIGH, 4'h0);
    carry = 1'h0;
    for (int i = 0; i < 9; i++) begin
      op = nc_alu_op_e'(at[i][11:8]);
      wr(NC_PSW_LOW, {3'h0, at[i][12]});
      wr(7'h06, at[i][7:4]);
      e = arith(op, at[i][7:4], at[i][3:0], carry, at[i][12]);
      alu(op, at[i][3:0], e[3:0], {1'h0, e[4], e[3:0] == 4'h0, at[i][12]}, 1'h0);
      rdc(7'h06, e[3:0]);
      carry = e[4];
    end
    // Out of range only carry and a value of ten or more are promised
    foreach (ov[i]) begin
      wr(7'h06, ov[i][7:4]);
      alu_go <= 1'h1;
      alu_op <= nc_alu_op_e'(ov[i][11:8]);
      alu_addr <= 7'h06;
      alu_imm <= ov[i][3:0];
      @(posedge sys_clk);
      alu_go <= 1'h0;
      @(negedge sys_clk);
      `CHK(flags, 4'h5)
      `CHK(alu_result >= 4'hA, 1'h1)
      @(posedge sys_clk);
    end
    $display("test arithmetic done");
    wr(NC_PSW_LOW, 4'h0);
    wr(NC_PSW_HIGH, 4'hE);
    wr(7'h06, 4'h5);
    alu(NC_OP_SKIP_IF_EQUAL, 4'h5, 4'h0, 4'hE, 1'h1);
    alu(NC_OP_SKIP_IF_UNEQUAL, 4'h3, 4'h2, 4'hC, 1'h1);
    alu(NC_OP_SKIP_IF_EQUAL, 4'h5, 4'h0, 4'hC, 1'h1);
    alu(NC_OP_SKIP_IF_GREATER_OR_EQUAL, 4'h6, 4'hF, 4'hC, 1'h0);
    alu(NC_OP_SKIP_IF_LESS_THAN, 4'h6, 4'hF, 4'hC, 1'h1);
    alu(NC_OP_ADD, 4'h3, 4'h8, 4'h8, 1'h0);
    $display("test compare done");
    alu(NC_OP_AND, 4'hC, 4'h8, 4'h8, 1'h0);
    alu(NC_OP_OR, 4'h3, 4'hB, 4'h8, 1'h0);
    alu(NC_OP_XOR, 4'hF, 4'h4, 4'h8, 1'h0);
    alu(NC_OP_TEST_TRUE, 4'h4, 4'h4, 4'h8, 1'h1);
    alu(NC_OP_TEST_FALSE, 4'h3, 4'h4, 4'h8, 1'h1);
    alu(NC_OP_RORC, 4'h0, 4'h2, 4'h8, 1'h0);
    alu(NC_OP_LOAD, 4'h9, 4'h9, 4'h8, 1'h0);
    rdc(7'h06, 4'h9);
    $display("test logic done");
    stop_test;
  end
endmodule
bind nc_core nc_core_monitor u_mon (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .IP_CMD(IP_CMD),
  .IP_TARGET(IP_TARGET), .IP_VALUE(IP_VALUE), .MEM_WR(MEM_WR), .MEM_ADDR(MEM_ADDR),
  .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA), .ALU_GO(ALU_GO), .ALU_OP(ALU_OP),
  .ALU_RESULT(ALU_RESULT), .FLAGS(FLAGS), .PORT_PIN_OUT(PORT_PIN_OUT),
  .PORT_PIN_OE(PORT_PIN_OE));
`default_nettype wire
